// *** fldo_top.v ***
// Fast level-detect pin logic for one converter channel
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "fldo_consts.vh"
module fldo_top #(
	parameter DWELL_W = 16
) (
	input  wire        ref_clk,
	input  wire        resetn,
	input  wire [13:0] fast_sample,
	input  wire [13:0] full_sample,
	input  wire        output_data_clock,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	output reg  [3:0]  fast_level_pins
);
	reg  [7:0]         ctrl;
	reg  [2:0]         coarse_thr;
	reg  [12:0]        fine_hi_thr;
	reg  [12:0]        fine_lo_thr;
	reg  [DWELL_W-1:0] dwell;
	reg  [DWELL_W-1:0] dwell_cnt;
	reg  [1:0]         odc_sync;
	reg                odc_prev;
	reg                pair_phase;
	reg  [3:0]         pair_max;
	reg                coarse_high_limit_hit;
	reg  [1:0]         ch_hold;
	reg                fine_high_limit_hit;
	reg                fine_low_limit_hit;
	reg                raise_gain_request;
	reg                over_range;
	reg  [3:0]         next_pins;
	reg  [3:0]         slow_mag;
	wire [3:0]         fast_mag;
	wire [12:0]        fast_abs;
	wire [12:0]        full_abs;
	wire [3:0]         mag_fast_d;
	wire [3:0]         pins_slow_d;
	wire [3:0]         cmos_pins;
	wire [2:0]         mode;
	wire               enable;
	wire               lvds;
	wire               odc_edge;
	wire [2:0]         mag3;
	wire [1:0]         mag2;
	wire               ch_cmp;
	wire               raw_ovf;
	wire               or_d;
	// Hold count loaded on a hit; one extra cycle gives the two-cycle minimum pulse
	localparam integer HOLD_LOAD = `FLDO_HOLD_MIN - 1;

	assign enable = ctrl[`FLDO_CTRL_EN_BIT];
	assign mode   = ctrl[`FLDO_CTRL_MODE_LSB+2:`FLDO_CTRL_MODE_LSB];
	assign lvds   = ctrl[`FLDO_CTRL_LVDS_BIT];

	fldo_mag u_fast (
		.sample  (fast_sample),
		.mag4    (fast_mag),
		.abs_mag (fast_abs)
	);
	fldo_mag u_full (
		.sample  (full_sample),
		.mag4    (),
		.abs_mag (full_abs)
	);

	// Register file: writes steer detection, status shows live indicators
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl        <= `FLDO_CTRL_RESET;
			coarse_thr  <= `FLDO_COARSE_RESET;
			fine_hi_thr <= `FLDO_FINE_HI_RESET;
			fine_lo_thr <= `FLDO_FINE_LO_RESET;
			dwell       <= `FLDO_DWELL_RESET;
			reg_rdata   <= 8'h00;
		end else begin
			if (reg_wr) begin
				case (reg_addr)
					`FLDO_REG_CTRL:       ctrl <= {3'b000, reg_wdata[4:0]};
					`FLDO_REG_COARSE_THR: coarse_thr <= reg_wdata[2:0];
					`FLDO_REG_FINE_HI_LO: fine_hi_thr[7:0] <= reg_wdata;
					`FLDO_REG_FINE_HI_HI: fine_hi_thr[12:8] <= reg_wdata[4:0];
					`FLDO_REG_FINE_LO_LO: fine_lo_thr[7:0] <= reg_wdata;
					`FLDO_REG_FINE_LO_HI: fine_lo_thr[12:8] <= reg_wdata[4:0];
					`FLDO_REG_DWELL_LO:   dwell[7:0] <= reg_wdata;
					`FLDO_REG_DWELL_HI:   dwell[15:8] <= reg_wdata;
					default: ;
				endcase
			end
			if (reg_rd) begin
				case (reg_addr)
					`FLDO_REG_CTRL:       reg_rdata <= ctrl;
					`FLDO_REG_COARSE_THR: reg_rdata <= {5'h00, coarse_thr};
					`FLDO_REG_FINE_HI_LO: reg_rdata <= fine_hi_thr[7:0];
					`FLDO_REG_FINE_HI_HI: reg_rdata <= {3'h0, fine_hi_thr[12:8]};
					`FLDO_REG_FINE_LO_LO: reg_rdata <= fine_lo_thr[7:0];
					`FLDO_REG_FINE_LO_HI: reg_rdata <= {3'h0, fine_lo_thr[12:8]};
					`FLDO_REG_DWELL_LO:   reg_rdata <= dwell[7:0];
					`FLDO_REG_DWELL_HI:   reg_rdata <= dwell[15:8];
					`FLDO_REG_STATUS:     reg_rdata <= {3'h0, over_range, coarse_high_limit_hit,
						fine_high_limit_hit, fine_low_limit_hit, raise_gain_request};
					default:              reg_rdata <= 8'h00;
				endcase
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// Output data clock comes from another domain: two flops before use
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			odc_sync <= 2'b00;
			odc_prev <= 1'b0;
		end else begin
			odc_sync <= {odc_sync[0], output_data_clock};
			odc_prev <= odc_sync[1];
		end
	end
	// Both edges mark a pin update, matching the receiver's dual-edge capture
	assign odc_edge = odc_sync[1] ^ odc_prev;

	// Peak-hold of the early magnitude across each sample pair
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pair_phase <= 1'b0;
			pair_max   <= 4'h0;
			slow_mag   <= 4'h0;
		end else begin
			pair_phase <= ~pair_phase;
			if (!pair_phase)
				pair_max <= fast_mag;
			else
				slow_mag <= (fast_mag > pair_max) ? fast_mag : pair_max;
		end
	end

	// 3-bit and 2-bit coarse codes saturate the 4-bit scale
	assign mag3 = slow_mag[3] ? 3'h7 : slow_mag[2:0];
	assign mag2 = (slow_mag >= 4'h6) ? 2'h3 : (slow_mag >= 4'h4) ? 2'h2 :
		(slow_mag >= 4'h2) ? 2'h1 : 2'h0;

	// Coarse-high on the early path; magnitude 8 also counts as top band
	assign ch_cmp = ((fast_mag[3] ? 3'h7 : fast_mag[2:0]) > coarse_thr) || (fast_mag[3]
		&& coarse_thr == 3'h7);
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			coarse_high_limit_hit <= 1'b0;
			ch_hold               <= 2'b00;
		end else if (ch_cmp) begin
			coarse_high_limit_hit <= 1'b1;
			ch_hold               <= HOLD_LOAD[1:0];
		end else if (ch_hold != 2'b00) begin
			ch_hold <= ch_hold - 2'b01; // Minimum pulse keeps short peaks visible
		end else begin
			coarse_high_limit_hit <= 1'b0;
		end
	end

	// Normal overflow: full-scale code either sign
	assign raw_ovf = (full_sample == 14'h1FFF) || (full_sample == 14'h2000);
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fine_high_limit_hit <= 1'b0;
			fine_low_limit_hit  <= 1'b0;
			over_range          <= 1'b0;
		end else begin
			fine_high_limit_hit <= (full_abs > fine_hi_thr);
			fine_low_limit_hit  <= (full_abs < fine_lo_thr);
			over_range          <= raw_ovf;
		end
	end

	// Pipeline latency ahead of the overrange flag
	fldo_delay #(
		.WIDTH (1),
		.DEPTH (`FLDO_LAT_OVERRANGE - 1)
	) u_or_dly (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.din     (over_range),
		.dout    (or_d)
	);

	// Dwell counter: raise-gain only after a long quiet stretch
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			dwell_cnt          <= {DWELL_W{1'b0}};
			raise_gain_request <= 1'b0;
		end else if (!fine_low_limit_hit) begin
			dwell_cnt          <= {DWELL_W{1'b0}};
			raise_gain_request <= 1'b0;
		end else if (dwell_cnt >= dwell) begin
			raise_gain_request <= 1'b1;
		end else begin
			dwell_cnt <= dwell_cnt + 1'b1;
		end
	end

	// Pin mux; undefined codes fall back to the 4-bit magnitude
	always @* begin
		case (mode)
			`FLDO_MODE_MAG3_OR: next_pins = {mag3, or_d};
			`FLDO_MODE_MAG2_OR: next_pins = {mag2, or_d, fine_low_limit_hit};
			`FLDO_MODE_MAG2_CH: next_pins = {mag2, coarse_high_limit_hit,
				fine_low_limit_hit};
			`FLDO_MODE_THRESH:  next_pins = {or_d, coarse_high_limit_hit,
				fine_high_limit_hit, fine_low_limit_hit};
			`FLDO_MODE_GAIN:    next_pins = {or_d, fine_high_limit_hit, raise_gain_request,
				coarse_high_limit_hit};
			default:            next_pins = slow_mag;
		endcase
	end

	// Fast path: two cycles from sample to pin in CMOS mode 000
	fldo_delay #(
		.WIDTH (4),
		.DEPTH (`FLDO_LAT_CMOS_FAST - 1)
	) u_fast_dly (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.din     (fast_mag),
		.dout    (mag_fast_d)
	);
	// Slow path totals six cycles including the output flop
	fldo_delay #(
		.WIDTH (4),
		.DEPTH (`FLDO_LAT_SLOW - 3)
	) u_slow_dly (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.din     (next_pins),
		.dout    (pins_slow_d)
	);

	assign cmos_pins = (mode == `FLDO_MODE_MAG4 || mode[2:1] == 2'b11) ? mag_fast_d : pins_slow_d;

	// In CMOS format, paired modes only change on output clock edges so each value is seen once
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			fast_level_pins <= 4'h0;
		else if (!enable)
			fast_level_pins <= 4'h0;
		else if (lvds)
			fast_level_pins <= pins_slow_d;
		else if (cmos_pins == mag_fast_d && (mode == `FLDO_MODE_MAG4 || mode[2:1] == 2'b11))
			fast_level_pins <= mag_fast_d;
		else if (odc_edge || mode >= `FLDO_MODE_THRESH)
			fast_level_pins <= pins_slow_d;
	end
endmodule // fldo_top
`default_nettype wire

// *** fldo_consts.vh ***
// Constants for the fast level-detect output block
`ifndef FLDO_CONSTS_VH
`define FLDO_CONSTS_VH
`define FLDO_REG_CTRL        8'h04
`define FLDO_REG_COARSE_THR  8'h05
`define FLDO_REG_FINE_HI_LO  8'h06
`define FLDO_REG_FINE_HI_HI  8'h07
`define FLDO_REG_FINE_LO_LO  8'h08
`define FLDO_REG_FINE_LO_HI  8'h09
`define FLDO_REG_DWELL_LO    8'h0A
`define FLDO_REG_DWELL_HI    8'h0B
`define FLDO_REG_STATUS      8'h0C
`define FLDO_CTRL_EN_BIT     0
`define FLDO_CTRL_MODE_LSB   1
`define FLDO_CTRL_LVDS_BIT   4
`define FLDO_CTRL_RESET      8'h00
`define FLDO_COARSE_RESET    3'h7
`define FLDO_FINE_HI_RESET   13'h1F00
`define FLDO_FINE_LO_RESET   13'h0100
`define FLDO_DWELL_RESET     16'h0001
`define FLDO_MODE_MAG4       3'h0
`define FLDO_MODE_MAG3_OR    3'h1
`define FLDO_MODE_MAG2_OR    3'h2
`define FLDO_MODE_MAG2_CH    3'h3
`define FLDO_MODE_THRESH     3'h4
`define FLDO_MODE_GAIN       3'h5
`define FLDO_LAT_CMOS_FAST   2
`define FLDO_LAT_SLOW        6
`define FLDO_LAT_OVERRANGE   12
`define FLDO_HOLD_MIN        2
`endif

// *** fldo_delay.v ***
// Fixed-length shift delay line
`timescale 1ns/10ps
`default_nettype none
module fldo_delay #(
	parameter WIDTH = 4,
	parameter DEPTH = 2
) (
	input  wire             ref_clk,
	input  wire             resetn,
	input  wire [WIDTH-1:0] din,
	output wire [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] stage [0:DEPTH-1];
	genvar i;
	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : g_stage
			always @(posedge ref_clk or negedge resetn) begin
				if (!resetn)
					stage[i] <= {WIDTH{1'b0}};
				else if (i == 0)
					stage[i] <= din;
				else
					stage[i] <= stage[(i == 0) ? 0 : i - 1];
			end
		end
	endgenerate
	assign dout = stage[DEPTH-1];
endmodule // fldo_delay
`default_nettype wire

// *** fldo_mag.v ***
// Coarse magnitude quantiser from early-stage sample
`timescale 1ns/10ps
`default_nettype none
module fldo_mag (
	input  wire [13:0] sample,
	output reg  [3:0]  mag4,
	output wire [12:0] abs_mag
);
	wire [13:0] inv;
	assign inv     = sample[13] ? ~sample : sample;
	// Ones-complement magnitude keeps both signs symmetric
	assign abs_mag = inv[12:0];
	always @* begin
		// Bands approximate -24,-14.5,-10,-7,-5,-3.25,-1.8,-0.56 dBFS
		if (abs_mag >= 13'd7670)
			mag4 = 4'h8;
		else if (abs_mag >= 13'd6662)
			mag4 = 4'h7;
		else if (abs_mag >= 13'd5636)
			mag4 = 4'h6;
		else if (abs_mag >= 13'd4607)
			mag4 = 4'h5;
		else if (abs_mag >= 13'd3657)
			mag4 = 4'h4;
		else if (abs_mag >= 13'd2591)
			mag4 = 4'h3;
		else if (abs_mag >= 13'd1544)
			mag4 = 4'h2;
		else if (abs_mag >= 13'd518)
			mag4 = 4'h1;
		else
			mag4 = 4'h0;
	end
endmodule // fldo_mag
`default_nettype wire

// *** fldo_gain_model.sv ***
// Far-side gain logic model: makes the data clock and samples the pins
`timescale 1ns/10ps
`default_nettype none
module fldo_gain_model (
	output var logic       output_data_clock,
	input  wire logic [3:0] fast_level_pins,
	output var logic [3:0] rise_pins,
	output var logic [3:0] fall_pins
);
	// Free-running, phase kept clear of the sample clock edges
	initial begin
		output_data_clock = 1'b0;
		#37;
		forever #160 output_data_clock = ~output_data_clock;
	end
	// Clock at one eighth of ref_clk with pins updated on both edges, so one edge alone would miss every other indication
	always @(posedge output_data_clock) rise_pins <= fast_level_pins;
	always @(negedge output_data_clock) fall_pins <= fast_level_pins;
endmodule // fldo_gain_model
`default_nettype wire

// *** fldo_checker.sv ***
// Checker for the fast level-detect pins
`timescale 1ns/10ps
`default_nettype none
module fldo_checker #(
	parameter DWELL_W = 16
) (
	input wire logic        ref_clk,
	input wire logic        resetn,
	input wire logic [13:0] fast_sample,
	input wire logic [13:0] full_sample,
	input wire logic        output_data_clock,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic [3:0]  fast_level_pins
);
	logic [4:0] ctrl;
	logic [2:0] cthr;
	logic [6:0] age;
	logic [6:0] loud;
	wire  [2:0] md = ctrl[3:1];
	wire        on = ctrl[0] && age > 7'd15;
	wire        m0c = on && !ctrl[4] && (md == 3'h0 || md[2:1] == 2'b11);
	wire        fsq = fast_sample == 14'h1FFF || fast_sample == 14'h2000;
	wire        fsf = full_sample == 14'h1FFF || full_sample == 14'h2000;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Shadow of the control fields; age lets the pipeline settle after a mode change
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl <= 5'h00;
			cthr <= 3'h7;
			age <= 7'h00;
			loud <= 7'h00;
		end else begin
			if (reg_wr && reg_addr == 8'h04)
				ctrl <= reg_wdata[4:0];
			if (reg_wr && reg_addr == 8'h05)
				cthr <= reg_wdata[2:0];
			age <= (reg_wr && reg_addr == 8'h04) ? 7'h00 : age + {6'h00, age != 7'h7F};
			loud <= (fsq && fsf) ? loud + {6'h00, loud != 7'h7F} : 7'h00;
		end
	end
	property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
	property p_ctrl;
		$past(reg_rd) && $past(reg_addr) == 8'h04 |-> reg_rdata == {3'h0, $past(ctrl)};
	endproperty
	property p_off; !ctrl[0] && age > 7'd3 |-> fast_level_pins == 4'h0; endproperty
	property p_zero; m0c && $past(fast_sample, 2) == 14'h0000 |-> fast_level_pins == 4'h0; endproperty
	property p_full; m0c && $past(fsq, 2) |-> fast_level_pins == 4'h8; endproperty
	property p_lvds; on && ctrl[4] && md == 3'h0 && $past(fsq, 6) |-> fast_level_pins == 4'h8; endproperty
	property p_pair; on && md == 3'h1 && loud > 7'd19 |-> fast_level_pins == 4'hF; endproperty
	property p_gain; on && md == 3'h5 && cthr == 3'h3 && loud > 7'd19 |-> fast_level_pins == 4'hD; endproperty
	a_idle: assert property (p_idle) else $error("read data not idle");
	a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
	a_off: assert property (p_off) else $error("pins active while off");
	a_zero: assert property (p_zero) else $error("quiet level wrong");
	a_full: assert property (p_full) else $error("full level wrong");
	a_lvds: assert property (p_lvds) else $error("wide format latency wrong");
	a_pair: assert property (p_pair) else $error("pair pins wrong");
	a_gain: assert property (p_gain) else $error("gain pins wrong");
	c_pair: cover property (on && md == 3'h1 && loud > 7'd19);
	c_gain: cover property (on && md == 3'h5 && fast_level_pins[1]);
	c_lvds: cover property (on && ctrl[4] && $past(fsq, 6));
endmodule // fldo_checker
bind fldo_top fldo_checker #(.DWELL_W(DWELL_W)) fldo_checker_inst (
	.ref_clk(ref_clk), .resetn(resetn), .fast_sample(fast_sample), .full_sample(full_sample),
	.output_data_clock(output_data_clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fast_level_pins(fast_level_pins)
);
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the fast level-detect pins
`timescale 1ns/10ps
`default_nettype none
module tb;
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [2:0]  thr;
		logic [13:0] s;
		logic [3:0]  exp;
	} fldo_row_t;
	localparam logic [13:0] P = 14'h1FFF;
	localparam logic [13:0] N = 14'h2000;
	localparam logic [13:0] Z = 14'h0000;
	logic        ref_clk, resetn, reg_wr, reg_rd, odc;
	logic [13:0] fast_sample, full_sample;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, got;
	logic [3:0]  pins, rise_pins, fall_pins;
	int          bad_count, cmp_count, cyc;
	logic [7:0]  rst_val [4:11] = '{8'h00, 8'h07, 8'h00, 8'h1F, 8'h00, 8'h01, 8'h01, 8'h00};
	fldo_row_t   rows [0:18] = '{
		{8'h01, 3'h7, Z, 4'h0},
		{8'h01, 3'h7, P, 4'h8},
		{8'h01, 3'h7, N, 4'h8},
		{8'h0D, 3'h7, P, 4'h8},
		{8'h0F, 3'h7, N, 4'h8},
		{8'h03, 3'h7, P, 4'hF},
		{8'h03, 3'h7, Z, 4'h0},
		{8'h05, 3'h7, N, 4'hE},
		{8'h05, 3'h7, Z, 4'h1},
		{8'h07, 3'h3, P, 4'hE},
		{8'h07, 3'h3, Z, 4'h1},
		{8'h09, 3'h3, N, 4'hE},
		{8'h09, 3'h3, Z, 4'h1},
		{8'h0B, 3'h3, P, 4'hD},
		{8'h0B, 3'h3, Z, 4'h2},
		{8'h00, 3'h3, P, 4'h0},
		{8'h0A, 3'h3, Z, 4'h0},
		{8'h11, 3'h7, N, 4'h8},
		{8'h1B, 3'h3, P, 4'hD}
	};
	fldo_top #(.DWELL_W(16)) fldo_top_inst (
		.ref_clk(ref_clk), .resetn(resetn), .fast_sample(fast_sample),
		.full_sample(full_sample), .output_data_clock(odc), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.fast_level_pins(pins)
	);
	fldo_gain_model fldo_gain_model_inst (
		.output_data_clock(odc), .fast_level_pins(pins),
		.rise_pins(rise_pins), .fall_pins(fall_pins)
	);
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Run is about 1200 cycles; the ceiling leaves generous room
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			bad_count++;
			stop_test();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 got = reg_rdata;
	endtask
	initial begin
		{resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = 19'h0_0000;
		fast_sample = Z;
		full_sample = Z;
		{bad_count, cmp_count, cyc} = '0;
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		foreach (rows[i]) begin
			wr(8'h05, {5'h00, rows[i].thr});
			wr(8'h04, rows[i].ctrl);
			fast_sample <= rows[i].s;
			full_sample <= rows[i].s;
			repeat (40) @(posedge ref_clk);
			#1 chk({4'h0, pins}, {4'h0, rows[i].exp});
			chk({4'h0, rise_pins}, {4'h0, rows[i].exp});
			chk({4'h0, fall_pins}, {4'h0, rows[i].exp});
			rd(8'h04);
			chk(got, rows[i].ctrl);
			$display("row %0d done", i);
		end
		wr(8'h04, 8'hFF);
		rd(8'h04);
		chk(got, 8'h1F);
		rd(8'h40);
		chk(got, 8'h00);
		$display("register map test done");
		// Period three pattern exposes any latency slip in either format
		full_sample <= Z;
		for (int k = 0; k < 2; k++) begin
			wr(8'h04, k[0] ? 8'h11 : 8'h01);
			for (int i = 0; i < 48; i++) begin
				@(posedge ref_clk);
				fast_sample <= (i % 3 == 0) ? P : Z;
			end
		end
		$display("latency test done");
		wr(8'h0A, 8'h28);
		wr(8'h0B, 8'h00);
		wr(8'h04, 8'h0B);
		fast_sample <= P;
		full_sample <= P;
		repeat (30) @(posedge ref_clk);
		fast_sample <= Z;
		full_sample <= Z;
		repeat (30) @(posedge ref_clk);
		#1 chk({7'h00, pins[1]}, 8'h00);
		repeat (110) @(posedge ref_clk);
		#1 chk({7'h00, pins[1]}, 8'h01);
		rd(8'h0C);
		chk(got, 8'h03);
		$display("dwell test done");
		resetn <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1 chk({4'h0, pins}, 8'h00);
		resetn <= 1'b1;
		for (int a = 4; a < 12; a++) begin
			rd(a[7:0]);
			chk(got, rst_val[a]);
		end
		$display("reset test done");
		stop_test();
	end
endmodule // tb
`default_nettype wire
